// ==== src/bcmcc_pkg.sv ====
// Purpose: shared constants for the boost converter mode and clock control block
// Assumes: 40 MHz mclk, APB register access with 32-bit data
// Notes:   register fields are 8 bits wide and sit in the low byte of each word
package bcmcc_pkg;

  // clock
  localparam int unsigned MCLK_PERIOD_NS = 25;

  // register byte addresses
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] CONFIG_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // reset values
  localparam logic [7:0] CTRL_RESET   = 8'h21;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // control register fields
  localparam int unsigned CTRL_VSEL_LSB  = 0;
  localparam int unsigned CTRL_SYNC_BIT  = 3;
  localparam int unsigned CTRL_RSVD_BIT  = 4;
  localparam int unsigned CTRL_SWSZ_BIT  = 5;
  localparam int unsigned CTRL_MIN_PULSE_WIDTH_SEL_LSB = 6;

  // config register fields
  localparam int unsigned CFG_SRC_BIT    = 0;
  localparam int unsigned CFG_FLOAT_BIT  = 1;
  localparam int unsigned CFG_ILIM_BIT   = 2;
  localparam int unsigned CFG_INV_BIT    = 3;
  localparam int unsigned CFG_ADCINV_BIT = 4;
  localparam int unsigned CFG_DIV_LSB    = 5;
  localparam int unsigned CFG_RSVD_BIT   = 7;

  // status register fields
  localparam int unsigned STAT_ONE_CELL_BIT = 0;
  localparam int unsigned STAT_CAPTURED_BIT = 1;
  localparam int unsigned STAT_ENABLE_BIT   = 2;
  localparam int unsigned STAT_SLEEP_BIT    = 3;

  // clock divider codes
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;

  // divider terminal counts (ratio minus one)
  localparam logic [1:0] DIV1_LAST = 2'h0;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // minimum pulse widths, rounded up to whole mclk cycles
  localparam int unsigned MIN_PULSE_WIDTH_SEL_1_NS = 20;
  localparam int unsigned MIN_PULSE_WIDTH_SEL_2_NS = 40;
  localparam int unsigned MIN_PULSE_WIDTH_SEL_3_NS = 80;
  localparam logic [2:0] MIN_PULSE_WIDTH_SEL_0_CYC = 3'h0;
  localparam logic [2:0] MIN_PULSE_WIDTH_SEL_1_CYC = 3'((MIN_PULSE_WIDTH_SEL_1_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [2:0] MIN_PULSE_WIDTH_SEL_2_CYC = 3'((MIN_PULSE_WIDTH_SEL_2_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [2:0] MIN_PULSE_WIDTH_SEL_3_CYC = 3'((MIN_PULSE_WIDTH_SEL_3_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // strap capture: last settle count after reset release; SETTLE lasts three cycles before the synchronised level is taken
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // strap capture sequence
  typedef enum logic [2:0] {
    BCMCC_ST_SETTLE  = 3'b001,
    BCMCC_ST_CAPTURE = 3'b010,
    BCMCC_ST_HELD    = 3'b100
  } bcmcc_strap_st_t;

endpackage : bcmcc_pkg

// ==== src/bcmcc_clk_if.sv ====
// Purpose: converter clock path signals shared by control, divider and pulse generator
// Assumes: all signals on mclk
// Notes:   tick is one mclk cycle wide, once per converter clock period
interface bcmcc_clk_if;
  logic       tick;
  logic [1:0] div_code;
  logic       invert;
  logic       local_osc;

  modport ctrl (output div_code, output invert, output local_osc, input tick);
  modport div  (input div_code, input invert, input local_osc, output tick);
  modport pwm  (input tick, input local_osc);
endinterface : bcmcc_clk_if

// ==== src/bcmcc_clk_div.sv ====
// Purpose: system clock divider for the converter clock path
// Assumes: mclk is the system clock; inversion modelled as a half-period phase shift
// Notes:   held idle while the local oscillator clocks the converter
module bcmcc_clk_div
  import bcmcc_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // clock path
  bcmcc_clk_if.div   cif
);
  import bcmcc_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] last;
  logic [1:0] phase;
  logic       tick_r;

  always_comb
  begin
    unique case (cif.div_code)
      DIV_BY_1: last = DIV1_LAST;
      DIV_BY_2: last = DIV2_LAST;
      DIV_BY_4: last = DIV4_LAST;
      default:  last = DIV4_LAST;
    endcase
    // inverted source: tick lands half a divided period later
    phase = cif.invert ? 2'((3'(last) + 3'h1) >> 1) : 2'h0; // R8
    if (phase > last)
      phase = 2'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end
    else if (cif.local_osc)
    begin
      cnt_r  <= 2'h0; // R15
      tick_r <= 1'b0; // R15
    end
    else
    begin
      cnt_r  <= (cnt_r >= last) ? 2'h0 : 2'(cnt_r + 2'h1); // R7 R14
      tick_r <= (cnt_r == phase); // R14
    end
  end

  assign cif.tick = tick_r;

endmodule : bcmcc_clk_div

// ==== src/bcmcc_pulse_gen.sv ====
// Purpose: switch drive pulse per converter clock with minimum width skipping
// Assumes: requested width in mclk cycles from the regulation loop, same clock
// Notes:   a new tick restarts the pulse; a too narrow request drops the whole pulse
module bcmcc_pulse_gen
  import bcmcc_pkg::*;
#(
  parameter int unsigned PW_W = 8
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // clock path
  bcmcc_clk_if.pwm             cif,
  // control
  input  wire logic            enable,
  input  wire logic [2:0]      min_cyc,
  input  wire logic [PW_W-1:0] width_req,
  // switch drive
  output logic                 drive,
  output logic                 skipped
);
  import bcmcc_pkg::*;

  logic [PW_W-1:0] left_r;
  logic            drive_r;
  logic            skip_r;
  logic            too_narrow;

  assign too_narrow = (width_req == '0) || (width_req < PW_W'(min_cyc));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_r  <= '0;
      drive_r <= 1'b0;
      skip_r  <= 1'b0;
    end
    else if (!enable || cif.local_osc)
    begin
      left_r  <= '0;
      drive_r <= 1'b0;
      skip_r  <= 1'b0;
    end
    else if (cif.tick)
    begin
      skip_r  <= too_narrow; // R11
      drive_r <= !too_narrow; // R11
      left_r  <= too_narrow ? '0 : PW_W'(width_req - PW_W'(1));
    end
    else
    begin
      skip_r  <= 1'b0;
      if (left_r != '0)
        left_r <= PW_W'(left_r - PW_W'(1));
      else
        drive_r <= 1'b0;
    end
  end

  assign drive   = drive_r;
  assign skipped = skip_r;

endmodule : bcmcc_pulse_gen

// ==== src/bcmcc_top.sv ====
// Purpose: mode strap capture, converter enable, clock path and switch control
// Assumes: arst_n is the power-on reset; other reset sources arrive on soft_rst_req
// Notes:   registers over APB, zero wait states
//
// How it works
// R1: each power-on reset samples the strap pin and latches one-cell or two-cell.
// R2: two-cell mode keeps the converter disabled in every power mode.
// R3: one-cell mode disables the converter in sleep, enables it otherwise.
// R4: latched mode changes only at power-on reset, never at runtime or soft reset.
// R5: board ties strap via inductor to battery or short to ground, never floating.
// R6: config bit 0 picks local oscillator or system clock for the converter.
// R7: two-bit divider on the system clock path; software keeps result in range.
// R8: invert bit set inverts the system clock ahead of the divider.
// R9: sleep with float clear disables converter and ties rail to battery.
// R10: sleep with float set leaves the output rail floating.
// R11: pulses narrower than the programmed minimum are skipped whole.
// R12: one bit sets both bypass and duty switches to large or small.
// R13: software should set the sync bit when using the analog converter.
// R14: divider codes 00, 01, 10 divide by 1, 2 and 4.
// R15: divider field is ignored while the local oscillator clocks the converter.
// R16: switch size bit 0 selects large switches, 1 selects small.
// R17: converter enable is one-cell and not sleep, following sleep promptly.
module bcmcc_top
  import bcmcc_pkg::*;
#(
  parameter int unsigned PW_W = 8
)
(
  // clock and power-on reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // other reset sources and power mode
  input  wire logic            soft_rst_req,
  input  wire logic            sleep,
  // board strap pin
  input  wire logic            converter_strap_pin,
  // regulation loop request
  input  wire logic [PW_W-1:0] pulse_width_req,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // mode and enable
  output logic                 one_cell,
  output logic                 conv_enable,
  // output rail in sleep
  output logic                 rail_tie_batt,
  output logic                 rail_float,
  // clock path
  output logic                 conv_clock_source_sel,
  output logic                 conv_clock_invert,
  output logic [1:0]           conv_clock_divider,
  output logic                 conv_clock_tick,
  // switches and analog settings
  output logic                 switch_drive,
  output logic                 pulse_skipped,
  output logic                 bypass_switch_small,
  output logic                 duty_switch_small,
  output logic                 peak_current_limit_sel,
  output logic [2:0]           vout_sel,
  output logic                 adc_sync_en,
  output logic                 adc_clock_invert
);
  import bcmcc_pkg::*;

  // reset release
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // strap synchroniser
  logic strap_meta_r;
  logic strap_sync_r;

  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
    end
    else
    begin
      strap_meta_r <= converter_strap_pin;
      strap_sync_r <= strap_meta_r;
    end
  end

  // strap capture, once per power-on reset
  bcmcc_strap_st_t strap_st_r;
  logic [1:0]      settle_r;
  logic            one_cell_r;
  logic            captured_r;

  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      strap_st_r <= BCMCC_ST_SETTLE;
      settle_r   <= 2'h0;
      one_cell_r <= 1'b0;
      captured_r <= 1'b0;
    end
    else
    begin
      unique case (strap_st_r)
        BCMCC_ST_SETTLE:
        begin
          settle_r <= 2'(settle_r + 2'h1);
          if (settle_r == STRAP_SETTLE_CYC)
            strap_st_r <= BCMCC_ST_CAPTURE;
        end
        BCMCC_ST_CAPTURE:
        begin
          // inductor to battery reads high, short to ground reads low
          one_cell_r <= strap_sync_r; // R1 R5
          captured_r <= 1'b1;
          strap_st_r <= BCMCC_ST_HELD;
        end
        BCMCC_ST_HELD:
        begin
          strap_st_r <= BCMCC_ST_HELD; // R4
        end
        default:
        begin
          strap_st_r <= BCMCC_ST_HELD;
        end
      endcase
    end
  end

  // APB access decode
  logic        pready_r;
  logic       setup_ph;
  logic       wr_acc;
  logic       hit_ctrl;
  logic       hit_cfg;
  logic       hit_stat;
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic [7:0] stat_v;
  logic [7:0] rd_v;
  logic       conv_en_r;
  logic       tie_r;
  logic       float_r;

  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pready_r && pwrite && pstrb[0];
  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign hit_cfg  = (paddr == CONFIG_OFFSET);
  assign hit_stat = (paddr == STATUS_OFFSET);

  // control register, restored by any reset source
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ctrl_r <= CTRL_RESET;
    else if (soft_rst_req)
      ctrl_r <= CTRL_RESET;
    else if (wr_acc && hit_ctrl)
    begin
      ctrl_r                <= pwdata[7:0];
      ctrl_r[CTRL_RSVD_BIT] <= 1'b0;
    end
  end

  // config register, restored by any reset source
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      cfg_r <= CONFIG_RESET;
    else if (soft_rst_req)
      cfg_r <= CONFIG_RESET;
    else if (wr_acc && hit_cfg)
    begin
      cfg_r               <= pwdata[7:0];
      cfg_r[CFG_RSVD_BIT] <= 1'b0;
    end
  end

  always_comb
  begin
    stat_v                    = 8'h00;
    stat_v[STAT_ONE_CELL_BIT] = one_cell_r;
    stat_v[STAT_CAPTURED_BIT] = captured_r;
    stat_v[STAT_ENABLE_BIT]   = conv_en_r;
    stat_v[STAT_SLEEP_BIT]    = sleep;
    if (hit_ctrl)
      rd_v = ctrl_r;
    else if (hit_cfg)
      rd_v = cfg_r;
    else if (hit_stat)
      rd_v = stat_v;
    else
      rd_v = 8'h00;
  end

  // APB answer, prepared in the setup cycle
  logic [31:0] prdata_r;
  logic        pslverr_r;

  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= 1'b1;
      if (setup_ph)
      begin
        prdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_v};
        pslverr_r <= !(hit_ctrl || hit_cfg || hit_stat);
      end
    end
  end

  // converter enable and rail state
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      conv_en_r <= 1'b0;
      tie_r     <= 1'b0;
      float_r   <= 1'b0;
    end
    else
    begin
      conv_en_r <= one_cell_r && !sleep; // R2 R3 R9 R17
      tie_r     <= sleep && !cfg_r[CFG_FLOAT_BIT]; // R9
      float_r   <= sleep && cfg_r[CFG_FLOAT_BIT]; // R10
    end
  end

  // clock path
  bcmcc_clk_if cif ();

  assign cif.local_osc = !cfg_r[CFG_SRC_BIT]; // R6
  assign cif.invert    = cfg_r[CFG_INV_BIT]; // R8
  assign cif.div_code  = cfg_r[CFG_DIV_LSB +: 2]; // R7

  bcmcc_clk_div u_clk_div (
    .clk   (mclk),
    .rst_n (rst_n_r),
    .cif   (cif.div)
  );

  // minimum pulse width decode
  logic [2:0] min_cyc;

  always_comb
  begin
    unique case (ctrl_r[CTRL_MIN_PULSE_WIDTH_SEL_LSB +: 2])
      2'h0: min_cyc = MIN_PULSE_WIDTH_SEL_0_CYC;
      2'h1: min_cyc = MIN_PULSE_WIDTH_SEL_1_CYC;
      2'h2: min_cyc = MIN_PULSE_WIDTH_SEL_2_CYC;
      2'h3: min_cyc = MIN_PULSE_WIDTH_SEL_3_CYC;
    endcase
  end

  logic drive_w;
  logic skip_w;

  bcmcc_pulse_gen #(
    .PW_W (PW_W)
  ) u_pulse_gen (
    .clk       (mclk),
    .rst_n     (rst_n_r),
    .cif       (cif.pwm),
    .enable    (conv_en_r),
    .min_cyc   (min_cyc),
    .width_req (pulse_width_req),
    .drive     (drive_w),
    .skipped   (skip_w)
  );

  // outputs
  assign prdata                 = prdata_r;
  assign pready                 = pready_r;
  assign pslverr                = pslverr_r;
  assign one_cell               = one_cell_r;
  assign conv_enable            = conv_en_r;
  assign rail_tie_batt          = tie_r;
  assign rail_float             = float_r;
  assign conv_clock_source_sel  = cfg_r[CFG_SRC_BIT];
  assign conv_clock_invert      = cfg_r[CFG_INV_BIT];
  assign conv_clock_divider     = cfg_r[CFG_DIV_LSB +: 2];
  assign conv_clock_tick        = cif.tick;
  assign switch_drive           = drive_w;
  assign pulse_skipped          = skip_w;
  assign bypass_switch_small    = ctrl_r[CTRL_SWSZ_BIT]; // R12 R16
  assign duty_switch_small      = ctrl_r[CTRL_SWSZ_BIT]; // R12 R16
  assign peak_current_limit_sel = cfg_r[CFG_ILIM_BIT];
  assign vout_sel               = ctrl_r[CTRL_VSEL_LSB +: 3];
  assign adc_sync_en            = ctrl_r[CTRL_SYNC_BIT]; // R13
  assign adc_clock_invert       = cfg_r[CFG_ADCINV_BIT];

endmodule : bcmcc_top

// ==== dv/bcmcc_checker.sv ====
// Purpose: port assertions for the converter control top
// Assumes: one mclk domain, arst_n is the power-on reset
// Notes:   bound into every bcmcc_top instance
module bcmcc_checker
  import bcmcc_pkg::*;
(
  // clock, reset and inputs
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       sleep,
  input wire logic       psel,
  // watched outputs
  input wire logic       one_cell,
  input wire logic       conv_enable,
  input wire logic       rail_tie_batt,
  input wire logic       rail_float,
  input wire logic       conv_clock_source_sel,
  input wire logic [1:0] conv_clock_divider,
  input wire logic       conv_clock_tick,
  input wire logic       switch_drive,
  input wire logic       pulse_skipped
);
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  property p_two_cell;
    !one_cell |-> !conv_enable;
  endproperty
  a_two_cell: assert property (p_two_cell) else $error("enable in two-cell");
  property p_en;
    1'b1 |=> conv_enable == ($past(one_cell) && !$past(sleep));
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_rail;
    1'b1 |=> ($past(sleep) ? (rail_tie_batt ^ rail_float) : !(rail_tie_batt || rail_float));
  endproperty
  a_rail: assert property (p_rail) else $error("rail state wrong");
  property p_mode_hold;
    !$fell(one_cell);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode lost");
  property p_local;
    !conv_clock_source_sel [*3] |-> !conv_clock_tick;
  endproperty
  a_local: assert property (p_local) else $error("tick on local osc");
  property p_div4;
    conv_clock_tick && conv_clock_source_sel && conv_clock_divider == DIV_BY_4
      && !$past(psel) && !$past(psel, 2)
      |=> (!conv_clock_tick [*3] ##1 conv_clock_tick) or (##[0:2] psel);
  endproperty
  a_div4: assert property (p_div4) else $error("tick period not 4");
  property p_skip;
    pulse_skipped |-> !switch_drive;
  endproperty
  a_skip: assert property (p_skip) else $error("drive on skip");
  property p_gate;
    !conv_enable [*2] |-> !switch_drive;
  endproperty
  a_gate: assert property (p_gate) else $error("drive while off");
endmodule : bcmcc_checker

bind bcmcc_top bcmcc_checker chk_u (
  .mclk(mclk), .arst_n(arst_n), .sleep(sleep), .psel(psel), .one_cell(one_cell),
  .conv_enable(conv_enable), .rail_tie_batt(rail_tie_batt), .rail_float(rail_float),
  .conv_clock_source_sel(conv_clock_source_sel), .conv_clock_divider(conv_clock_divider),
  .conv_clock_tick(conv_clock_tick), .switch_drive(switch_drive),
  .pulse_skipped(pulse_skipped)
);

// ==== dv/bcmcc_pmc_model.sv ====
// Purpose: power mode controller and strap pin stand-in
// Assumes: commands from the bench on mclk
// Notes:   strap always driven, never left open
module bcmcc_pmc_model (
  // clock and commands
  input wire logic mclk,
  input wire logic sleep_cmd,
  input wire logic strap_cmd,
  // to the block
  output logic     sleep,
  output logic     converter_strap_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sleep = 1'b0;
    converter_strap_pin = 1'b0;
  end
  always @(posedge mclk)
  begin
    sleep <= sleep_cmd;
    converter_strap_pin <= strap_cmd;
  end
endmodule : bcmcc_pmc_model

// ==== dv/boost_converter_mode_and_clock_ctrl_bench.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: default pulse width port, APB on mclk
// Notes:   register mirror in the bench, random data from a fixed seed
module boost_converter_mode_and_clock_ctrl_bench;
  import bcmcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, arst_n, soft_rst_req, sleep, strap_pin, sleep_cmd, strap_cmd;
  logic        psel, penable, pwrite, pready, pslverr, one_cell, conv_enable;
  logic        rail_tie_batt, rail_float, conv_clock_tick, switch_drive, pulse_skipped;
  logic        src_sel, clk_inv, sw_byp, sw_duty, ilim, sync_en, adc_inv;
  logic [1:0]  clk_div;
  logic [2:0]  vout;
  logic [3:0]  pstrb;
  logic [7:0]  width_req, m_ctrl, m_cfg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  mc [4] = '{MIN_PULSE_WIDTH_SEL_0_CYC, MIN_PULSE_WIDTH_SEL_1_CYC, MIN_PULSE_WIDTH_SEL_2_CYC, MIN_PULSE_WIDTH_SEL_3_CYC};
  int          cyc = 0, n_mismatch = 0, samples_checked = 0;

  bcmcc_top dut_u (
    .mclk(mclk), .arst_n(arst_n), .soft_rst_req(soft_rst_req), .sleep(sleep),
    .converter_strap_pin(strap_pin), .pulse_width_req(width_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .one_cell(one_cell),
    .conv_enable(conv_enable), .rail_tie_batt(rail_tie_batt), .rail_float(rail_float),
    .conv_clock_source_sel(src_sel), .conv_clock_invert(clk_inv),
    .conv_clock_divider(clk_div), .conv_clock_tick(conv_clock_tick),
    .switch_drive(switch_drive), .pulse_skipped(pulse_skipped), .bypass_switch_small(sw_byp),
    .duty_switch_small(sw_duty), .peak_current_limit_sel(ilim), .vout_sel(vout),
    .adc_sync_en(sync_en), .adc_clock_invert(adc_inv)
  );
  bcmcc_pmc_model pmc_u (
    .mclk(mclk), .sleep_cmd(sleep_cmd), .strap_cmd(strap_cmd), .sleep(sleep),
    .converter_strap_pin(strap_pin)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge mclk);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
    if (a == CTRL_OFFSET) m_ctrl = d[7:0] & 8'hEF;
    if (a == CONFIG_OFFSET) m_cfg = d[7:0] & 8'h7F;
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0, r, e);
    chk("prdata", r, x);
    chk("pslverr", 32'(e), 32'(xe));
  endtask : rd_chk

  task automatic wait_tick();
    int n;
    @(negedge mclk);
    for (n = 0; n < 40 && conv_clock_tick !== 1'b1; n++) @(negedge mclk);
    if (conv_clock_tick !== 1'b1) n_mismatch++;
  endtask : wait_tick

  task automatic po_reset(input logic s);
    strap_cmd <= s;
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    m_ctrl = CTRL_RESET;
    m_cfg = CONFIG_RESET;
    repeat (12) @(posedge mclk);
    chk("one_cell", 32'(one_cell), 32'(s));
    rd_chk(STATUS_OFFSET, {28'h0, 1'b0, s, 1'b1, s}, 1'b0);
    rd_chk(CTRL_OFFSET, {24'h0, CTRL_RESET}, 1'b0);
    rd_chk(CONFIG_OFFSET, {24'h0, CONFIG_RESET}, 1'b0);
  endtask : po_reset

  initial
  begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    int t0, nd, ns, sk;
    void'($urandom(32'h1FF4));
    {soft_rst_req, sleep_cmd, strap_cmd, psel, penable, pwrite} = 6'h0;
    {paddr, pwdata, width_req} = '0;
    pstrb = 4'hF;
    arst_n = 1'b0;
    po_reset(1'b0);
    po_reset(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(CTRL_OFFSET, $urandom());
      wr(CONFIG_OFFSET, $urandom());
      wr(STATUS_OFFSET, $urandom());
      wr(12'h00C, $urandom());
      @(negedge mclk);
      chk("outs", {vout, sync_en, sw_byp, sw_duty, src_sel, ilim, clk_inv, adc_inv, clk_div},
          {m_ctrl[2:0], m_ctrl[3], m_ctrl[5], m_ctrl[5], m_cfg[0], m_cfg[2], m_cfg[3],
           m_cfg[4], m_cfg[6:5]});
      rd_chk(CTRL_OFFSET, {24'h0, m_ctrl}, 1'b0);
      rd_chk(CONFIG_OFFSET, {24'h0, m_cfg}, 1'b0);
      rd_chk(12'h00C, 32'h0, 1'b0 == 1'b0);
    end
    for (int f = 0; f < 2; f++)
    begin
      wr(CTRL_OFFSET, 32'h29);
      wr(CONFIG_OFFSET, 32'(f << 1));
      sleep_cmd <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("sleep rails", {conv_enable, rail_tie_batt, rail_float}, {1'b0, f == 0, f == 1});
      rd_chk(STATUS_OFFSET, 32'h0B, 1'b0);
      sleep_cmd <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("wake", {conv_enable, rail_tie_batt, rail_float}, 3'h4);
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(CONFIG_OFFSET, {24'($urandom()), 8'(k << 5) | 8'h01});
      // first tick may still come from the old ratio
      wait_tick();
      wait_tick();
      t0 = cyc;
      wait_tick();
      chk("tick period", 32'(cyc - t0), 32'(1 << k));
    end
    wr(CONFIG_OFFSET, 32'h20);
    @(posedge mclk);
    nd = 0;
    repeat (16)
    begin
      @(negedge mclk);
      nd += int'(conv_clock_tick === 1'b1);
    end
    chk("local ticks", 32'(nd), 32'h0);
    wr(CONFIG_OFFSET, 32'h41);
    wait_tick();
    t0 = cyc;
    wr(CONFIG_OFFSET, 32'h49);
    wait_tick();
    wait_tick();
    chk("invert phase", 32'((cyc - t0) % 4), 32'h2);
    wr(CONFIG_OFFSET, 32'h41);
    for (int m = 0; m < 4; m++)
    begin
      for (int w = 0; w < 4; w++)
      begin
        wr(CTRL_OFFSET, 32'(m << 6) | 32'h21);
        width_req <= 8'(w);
        wait_tick();
        wait_tick();
        {nd, ns} = '0;
        repeat (4)
        begin
          @(negedge mclk);
          nd += int'(switch_drive === 1'b1);
          ns += int'(pulse_skipped === 1'b1);
        end
        sk = int'(w == 0 || w < int'(mc[m]));
        chk("drive cycles", 32'(nd), (sk != 0) ? 32'h0 : 32'(w));
        chk("skips", 32'(ns), 32'(sk));
      end
    end
    wr(CTRL_OFFSET, $urandom());
    wr(CONFIG_OFFSET, $urandom() & 32'hFFFFFFFE);
    strap_cmd <= 1'b0;
    repeat (6) @(posedge mclk);
    soft_rst_req <= 1'b1;
    @(posedge mclk);
    soft_rst_req <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("mode kept", 32'(one_cell), 32'h1);
    rd_chk(CTRL_OFFSET, {24'h0, CTRL_RESET}, 1'b0);
    rd_chk(CONFIG_OFFSET, {24'h0, CONFIG_RESET}, 1'b0);
    close_out();
  end
endmodule : boost_converter_mode_and_clock_ctrl_bench
